/* hw/sfe_irq.sv */
`timescale 1ns/1ps
// ****************************************************************
// sticky interrupt status with enable and write-one clear
// ****************************************************************
module sfe_irq import sfe_pkg::*; #(
  parameter int W = IRQ_W
) (
  input  wire logic         clk_i,     // clock
  input  wire logic         rst_i,     // sync reset, high
  input  wire logic [W-1:0] evt_i,     // one-cycle events
  input  wire logic         en_wr_i,   // enable register write
  input  wire logic         clr_wr_i,  // clear register write
  input  wire logic [W-1:0] wdat_i,    // write data
  output logic      [W-1:0] stat_o,    // sticky status
  output logic      [W-1:0] en_o,      // enable mask
  output logic              irq_o      // level interrupt
);
  logic [W-1:0] stat_ff, nxt_stat; // sticky bits
  logic [W-1:0] en_ff, nxt_en;     // enables
  logic         irq_ff, nxt_irq;   // registered output

  // next values: an event in the clear cycle still sets its bit
  always_comb begin
    nxt_stat = (stat_ff & ~(clr_wr_i ? wdat_i : '0)) | evt_i;
    nxt_en   = en_wr_i ? wdat_i : en_ff;
    nxt_irq  = |(nxt_stat & nxt_en);
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
      en_ff   <= '0;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      en_ff   <= nxt_en;
      irq_ff  <= nxt_irq;
    end
  end

  assign stat_o = stat_ff;
  assign en_o   = en_ff;
  assign irq_o  = irq_ff;

  set_wins_a : assert property (@(posedge clk_i) disable iff (rst_i)
    |evt_i |=> ((stat_ff & $past(evt_i)) == $past(evt_i)))
    else $error("event lost against clear");
endmodule : sfe_irq

/* hw/sfe_match_cmp.sv */
`timescale 1ns/1ps
// ****************************************************************
// one-entry comparator
// ****************************************************************
module sfe_match_cmp import sfe_pkg::*; (
  input  wire logic [63:0] f_data_i,  // filter data, high word on top
  input  wire logic [63:0] f_mask_i,  // mask, 1 compares the bit
  input  wire logic [31:0] f_attr_i,  // filter attribute word
  input  wire logic [63:0] m_data_i,  // match data, high word on top
  input  wire logic [31:0] m_attr_i,  // match attribute word
  input  wire logic [15:0] diff_i,    // difference enable per byte
  output logic             hit_o      // entry matches
);
  logic [8:0] ok; // per-byte agreement after difference handling

  // data bytes: masked on both sides; a difference byte matches when unequal
  for (genvar k = 0; k < 8; k++) begin : g_byte
    assign ok[k] = diff_i[k] ^
      ((f_data_i[8*k+:8] & f_mask_i[8*k+:8]) == (m_data_i[8*k+:8] & f_mask_i[8*k+:8]));
  end
  // the non-maskable byte is never masked
  assign ok[8] = diff_i[8] ^ (f_attr_i[ATR_NM+:8] == m_attr_i[ATR_NM+:8]);

  assign hit_o = f_attr_i[ATR_EN] && &ok &&
                 (f_attr_i[ATR_PID+:PID_W] == m_attr_i[ATR_PID+:PID_W]);
endmodule : sfe_match_cmp

/* hw/sfe_pkg.sv */
// ****************************************************************
// section filter engine shared constants
// ****************************************************************
package sfe_pkg;
  // table geometry
  localparam int FLT_ENTRIES = 32;           // entries in the filter table
  localparam int IDX_W       = 5;            // bits of an entry index
  localparam int ADR_W       = 12;           // wishbone byte address width
  localparam int SRCH_MIN_CYC = 30;          // least cycles of a full search
  // register byte offsets
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STAT     = 12'h004;
  localparam logic [11:0] OFS_MHI      = 12'h008;
  localparam logic [11:0] OFS_MLO      = 12'h00c;
  localparam logic [11:0] OFS_MATTR    = 12'h010;
  localparam logic [11:0] OFS_RESULT   = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h01c;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h020;
  // table windows: filter at 0x400 (16 bytes/entry), mask at 0x600 (8 bytes/entry)
  localparam logic [2:0]  FLT_REGION   = 3'h2;
  localparam logic [3:0]  MSK_REGION   = 4'h6;
  // control register fields
  localparam int CTL_FRST  = 0;              // filter reset pulse
  localparam int CTL_ESC   = 1;              // escape on first match
  localparam int CTL_SSRST = 2;              // start/stop settings reset
  localparam int CTL_DMODE = 3;              // 1 local, 0 global difference
  localparam int CTL_DIFF  = 16;             // lsb of global difference enables
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_KEEP = 32'hffff_000a; // bits that store
  // attribute word fields
  localparam int ATR_PID  = 0;               // pid index lsb
  localparam int PID_W    = 6;               // pid index width
  localparam int ATR_EN   = 6;               // entry enable flag
  localparam int ATR_NM   = 8;               // non-maskable byte lsb
  localparam int ATR_DIFF = 16;              // lsb of local difference enables
  // status word fields
  localparam int ST_DONE  = 0;
  localparam int ST_FOUND = 1;
  localparam int ST_IDX   = 25;
  // interrupt sources
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FOUND = 1;
  localparam int IRQ_W     = 2;
  // search sequencer, gray along idle-run-finish
  typedef enum logic [1:0] {
    SFE_IDLE = 2'b00,
    SFE_RUN  = 2'b01,
    SFE_FIN  = 2'b11
  } sfe_state_t;
endpackage : sfe_pkg

/* hw/sfe_top.sv */
`timescale 1ns/1ps
// Function
// - control bit 0 resets only filter logic
// - escape flag stops search at first match
// - without escape all 32 entries are compared
// - result vector valid when search completes
// - control bit 2 clears start/stop settings
// - local mode takes enables from entry attribute
// - global mode takes enables from control 31:16
// - after reset attribute write starts a search
// - full search takes thirty or more cycles
// - match needs enable, pid, masked data equal
// - difference byte matches when bits differ
// - done cleared at start, found and index set
// - match data is double buffered
module sfe_top import sfe_pkg::*; #(
  parameter int N_ENT = FLT_ENTRIES   // filter table entries
) (
  input  wire logic             clk_i,     // 200 mhz clock
  input  wire logic             rst_i,     // sync reset, high
  input  wire logic             wb_cyc_i,  // wishbone cycle
  input  wire logic             wb_stb_i,  // wishbone strobe
  input  wire logic             wb_we_i,   // write enable
  input  wire logic [ADR_W-1:0] wb_adr_i,  // byte address
  input  wire logic [3:0]       wb_sel_i,  // byte lanes
  input  wire logic [31:0]      wb_dat_i,  // write data
  output logic      [31:0]      wb_dat_o,  // read data
  output logic                  wb_ack_o,  // acknowledge
  output logic                  irq_o      // search interrupt
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic             ack_ff, nxt_ack;          // bus answer
  logic [31:0]      rdat_ff, nxt_rdat;        // read data
  logic [31:0]      ctrl_ff, nxt_ctrl;        // stored control bits
  logic             frst_ff, nxt_frst;        // filter reset pulse
  logic             ssrst_ff, nxt_ssrst;      // start/stop reset pulse
  sfe_state_t       state_ff, nxt_state;      // search sequencer
  logic [IDX_W-1:0] idx_ff, nxt_idx;          // entry under test
  logic [N_ENT-1:0] res_ff, nxt_res;          // match result vector
  logic             done_ff, nxt_done;        // status done
  logic             found_ff, nxt_found;      // status found
  logic [IDX_W-1:0] first_ff, nxt_first;      // first match index
  logic             wsel_ff, nxt_wsel;        // buffer the cpu loads
  logic             ssel_ff, nxt_ssel;        // buffer the search reads
  logic [5:0]       cnt_ff, nxt_cnt;          // search length, checked only
  logic             req;                      // new bus request
  logic             wr_ctrl, wr_mhi, wr_mlo;  // register write strobes
  logic             wr_mat, wr_ien, wr_iclr;  // more write strobes
  logic             wr_flt, wr_msk;           // table write strobes
  logic             start;                    // search begins
  logic             hit;                      // current entry matches
  logic [15:0]      diff_en;                  // difference enables in use
  logic [IRQ_W-1:0] irq_evt, irq_stat, irq_en; // interrupt sideband
  logic [31:0]      wmerged;                  // lane-merged write value
  logic [IDX_W-1:0] f_ent, m_ent;             // table entry selectors
  // tables and double-buffered match data
  logic [31:0] flt_hi_m [N_ENT];
  logic [31:0] flt_lo_m [N_ENT];
  logic [31:0] flt_at_m [N_ENT];
  logic [31:0] msk_hi_m [N_ENT];
  logic [31:0] msk_lo_m [N_ENT];
  logic [31:0] mb_hi_m  [2];
  logic [31:0] mb_lo_m  [2];
  logic [31:0] mb_at_m  [2];

  // byte-lane merge of a write onto an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b+:8] = new_v[8*b+:8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************************************
  // wishbone slave: one answer, one cycle after the request
  // ****************************************************************
  assign req   = wb_cyc_i && wb_stb_i && !ack_ff;
  assign f_ent = wb_adr_i[8:4];
  assign m_ent = wb_adr_i[7:3];

  // write decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mhi  = 1'b0;
    wr_mlo  = 1'b0;
    wr_mat  = 1'b0;
    wr_ien  = 1'b0;
    wr_iclr = 1'b0;
    wr_flt  = 1'b0;
    wr_msk  = 1'b0;
    if (req && wb_we_i) begin
      if (wb_adr_i == OFS_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (wb_adr_i == OFS_MHI) begin
        wr_mhi = 1'b1;
      end else if (wb_adr_i == OFS_MLO) begin
        wr_mlo = 1'b1;
      end else if (wb_adr_i == OFS_MATTR) begin
        wr_mat = 1'b1;
      end else if (wb_adr_i == OFS_IRQ_EN) begin
        wr_ien = 1'b1;
      end else if (wb_adr_i == OFS_IRQ_CLR) begin
        wr_iclr = 1'b1;
      end else if (wb_adr_i[11:9] == FLT_REGION) begin
        wr_flt = 1'b1;
      end else if (wb_adr_i[11:8] == MSK_REGION) begin
        wr_msk = 1'b1;
      end
      // other writes are acknowledged and dropped
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    nxt_ack  = req;
    nxt_rdat = rdat_ff;
    if (req && !wb_we_i) begin
      if (wb_adr_i == OFS_CTRL) begin
        nxt_rdat = ctrl_ff;  // pulse bits read zero
      end else if (wb_adr_i == OFS_STAT) begin
        nxt_rdat = '0;
        nxt_rdat[ST_DONE]  = done_ff;
        nxt_rdat[ST_FOUND] = found_ff;
        nxt_rdat[ST_IDX+:IDX_W] = first_ff;
      end else if (wb_adr_i == OFS_MHI) begin
        nxt_rdat = mb_hi_m[wsel_ff];
      end else if (wb_adr_i == OFS_MLO) begin
        nxt_rdat = mb_lo_m[wsel_ff];
      end else if (wb_adr_i == OFS_MATTR) begin
        nxt_rdat = mb_at_m[wsel_ff];
      end else if (wb_adr_i == OFS_RESULT) begin
        nxt_rdat = 32'(res_ff);
      end else if (wb_adr_i == OFS_IRQ_STAT) begin
        nxt_rdat = 32'(irq_stat);
      end else if (wb_adr_i == OFS_IRQ_EN) begin
        nxt_rdat = 32'(irq_en);
      end else if (wb_adr_i[11:9] == FLT_REGION) begin
        case (wb_adr_i[3:2])
          2'h0:    nxt_rdat = flt_hi_m[f_ent];
          2'h1:    nxt_rdat = flt_lo_m[f_ent];
          2'h2:    nxt_rdat = flt_at_m[f_ent];
          default: nxt_rdat = '0;          // fourth word is empty
        endcase
      end else if (wb_adr_i[11:8] == MSK_REGION) begin
        nxt_rdat = wb_adr_i[2] ? msk_lo_m[m_ent] : msk_hi_m[m_ent];
      end else begin
        nxt_rdat = '0;
      end
    end
  end

  // ****************************************************************
  // control register and its pulses
  // ****************************************************************
  assign wmerged = merge(ctrl_ff, wb_dat_i, wb_sel_i);

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_frst  = 1'b0;
    nxt_ssrst = 1'b0;
    if (wr_ctrl) begin
      nxt_ctrl  = wmerged & CTRL_KEEP;
      nxt_frst  = wb_sel_i[0] && wb_dat_i[CTL_FRST];
      nxt_ssrst = wb_sel_i[0] && wb_dat_i[CTL_SSRST];
    end
  end

  // global or local difference enables
  assign diff_en = ctrl_ff[CTL_DMODE] ? flt_at_m[idx_ff][ATR_DIFF+:16]
                                      : ctrl_ff[CTL_DIFF+:16];

  // ****************************************************************
  // search sequencer
  // ****************************************************************
  // a start is refused while a search runs; software waits for done
  assign start = wr_mat && (state_ff == SFE_IDLE) && !frst_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_res   = res_ff;
    nxt_done  = done_ff;
    nxt_found = found_ff;
    nxt_first = first_ff;
    nxt_wsel  = wsel_ff;
    nxt_ssel  = ssel_ff;
    nxt_cnt   = (cnt_ff == '1) ? cnt_ff : cnt_ff + 6'd1;
    if (frst_ff) begin
      // the filter reset clears the engine but keeps the tables
      nxt_state = SFE_IDLE;
      nxt_idx   = '0;
      nxt_res   = '0;
      nxt_done  = 1'b0;
      nxt_found = 1'b0;
      nxt_first = '0;
      nxt_wsel  = 1'b0;
      nxt_ssel  = 1'b0;
    end else begin
      case (state_ff)
        SFE_IDLE: begin
          if (start) begin
            nxt_state = SFE_RUN;
            nxt_idx   = '0;
            nxt_res   = '0;
            nxt_done  = 1'b0;
            nxt_found = 1'b0;
            nxt_first = '0;
            nxt_ssel  = wsel_ff;
            nxt_wsel  = !wsel_ff;
            nxt_cnt   = '0;
          end
        end
        SFE_RUN: begin
          if (hit) begin
            nxt_res[idx_ff] = 1'b1;
            if (!found_ff) begin
              nxt_found = 1'b1;
              nxt_first = idx_ff;
            end
          end
          if (hit && ctrl_ff[CTL_ESC]) begin
            nxt_state = SFE_FIN;
          end else if (idx_ff == IDX_W'(N_ENT - 1)) begin
            nxt_state = SFE_FIN;
          end else begin
            nxt_idx = idx_ff + IDX_W'(1);
          end
        end
        SFE_FIN: begin
          nxt_done  = 1'b1;
          nxt_state = SFE_IDLE;
        end
        default: nxt_state = SFE_IDLE;
      endcase
    end
  end

  // the comparator looks at one entry per cycle
  sfe_match_cmp u_cmp (
    .f_data_i ({flt_hi_m[idx_ff], flt_lo_m[idx_ff]}),
    .f_mask_i ({msk_hi_m[idx_ff], msk_lo_m[idx_ff]}),
    .f_attr_i (flt_at_m[idx_ff]),
    .m_data_i ({mb_hi_m[ssel_ff], mb_lo_m[ssel_ff]}),
    .m_attr_i (mb_at_m[ssel_ff]),
    .diff_i   (diff_en),
    .hit_o    (hit)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdat_ff  <= '0;
      ctrl_ff  <= CTRL_RST;
      frst_ff  <= 1'b0;
      ssrst_ff <= 1'b0;
      state_ff <= SFE_IDLE;
      idx_ff   <= '0;
      res_ff   <= '0;
      done_ff  <= 1'b0;
      found_ff <= 1'b0;
      first_ff <= '0;
      wsel_ff  <= 1'b0;
      ssel_ff  <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
      ctrl_ff  <= nxt_ctrl;
      frst_ff  <= nxt_frst;
      ssrst_ff <= nxt_ssrst;
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      res_ff   <= nxt_res;
      done_ff  <= nxt_done;
      found_ff <= nxt_found;
      first_ff <= nxt_first;
      wsel_ff  <= nxt_wsel;
      ssel_ff  <= nxt_ssel;
      cnt_ff   <= nxt_cnt;
    end
  end

  // tables and match buffers: contents survive reset and filter reset; start/stop reset clears entry enables
  always_ff @(posedge clk_i) begin
    if (wr_flt) begin
      case (wb_adr_i[3:2])
        2'h0:    flt_hi_m[f_ent] <= merge(flt_hi_m[f_ent], wb_dat_i, wb_sel_i);
        2'h1:    flt_lo_m[f_ent] <= merge(flt_lo_m[f_ent], wb_dat_i, wb_sel_i);
        2'h2:    flt_at_m[f_ent] <= merge(flt_at_m[f_ent], wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    if (ssrst_ff) begin
      // start/stop reset disables every entry
      for (int e = 0; e < N_ENT; e++) begin
        flt_at_m[e][ATR_EN] <= 1'b0;
      end
    end
    if (wr_msk && wb_adr_i[2]) begin
      msk_lo_m[m_ent] <= merge(msk_lo_m[m_ent], wb_dat_i, wb_sel_i);
    end else if (wr_msk) begin
      msk_hi_m[m_ent] <= merge(msk_hi_m[m_ent], wb_dat_i, wb_sel_i);
    end
    // the cpu always loads the buffer the search is not using
    if (wr_mhi) begin
      mb_hi_m[wsel_ff] <= merge(mb_hi_m[wsel_ff], wb_dat_i, wb_sel_i);
    end
    if (wr_mlo) begin
      mb_lo_m[wsel_ff] <= merge(mb_lo_m[wsel_ff], wb_dat_i, wb_sel_i);
    end
    if (wr_mat) begin
      mb_at_m[wsel_ff] <= merge(mb_at_m[wsel_ff], wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_evt[IRQ_DONE]  = (state_ff == SFE_FIN) && !frst_ff;
  assign irq_evt[IRQ_FOUND] = (state_ff == SFE_FIN) && found_ff && !frst_ff;

  sfe_irq #(.W(IRQ_W)) u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    (irq_evt),
    .en_wr_i  (wr_ien),
    .clr_wr_i (wr_iclr),
    .wdat_i   (wb_dat_i[IRQ_W-1:0]),
    .stat_o   (irq_stat),
    .en_o     (irq_en),
    .irq_o    (irq_o)
  );

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  rst_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)
    frst_ff |=> !frst_ff || $past(wr_ctrl))
    else $error("filter reset pulse longer than one cycle");
  rst_idle_a : assert property (@(posedge clk_i) disable iff (rst_i)
    frst_ff |=> (state_ff == SFE_IDLE) && !done_ff && (res_ff == '0))
    else $error("filter reset did not clear the engine");
  start_run_a : assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> (state_ff == SFE_RUN) && (idx_ff == '0) && !done_ff)
    else $error("attribute write did not start a search");
  buf_flip_a : assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> (wsel_ff != $past(wsel_ff)) && (ssel_ff == $past(wsel_ff)))
    else $error("match buffers did not swap");
  escape_hit_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == SFE_RUN) && hit && ctrl_ff[CTL_ESC] && !frst_ff
      |=> (state_ff == SFE_FIN) ##1 (done_ff || $past(frst_ff)))
    else $error("escape on first match did not stop");
  full_scan_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == SFE_RUN) && !frst_ff && !(hit && ctrl_ff[CTL_ESC])
      && (idx_ff != IDX_W'(N_ENT - 1)) |=> (state_ff == SFE_RUN))
    else $error("search ended before the last entry");
  search_len_a : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_ff) && !ctrl_ff[CTL_ESC] |-> (cnt_ff >= 6'(SRCH_MIN_CYC)))
    else $error("full search shorter than thirty cycles");
  found_res_a : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_ff) |-> (found_ff == (res_ff != '0))
      && (!found_ff || res_ff[first_ff]))
    else $error("status word disagrees with result vector");
  ss_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ssrst_ff && !wr_flt |=> !flt_at_m[0][ATR_EN] && !flt_at_m[N_ENT-1][ATR_EN])
    else $error("start/stop reset left entries enabled");
  bus_ack_a : assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_ff ##1 !ack_ff)
    else $error("wishbone answer not one cycle wide");
endmodule : sfe_top

/* tb/sfe_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// host firmware model: classic wishbone single cycles
// ****************************************************************
module sfe_host_model import sfe_pkg::*; (
  input  wire logic             clk_i,   // bus clock
  input  wire logic             ack_i,   // slave acknowledge
  input  wire logic [31:0]      rdat_i,  // slave read data
  output logic                  cyc_o,   // cycle
  output logic                  stb_o,   // strobe
  output logic                  we_o,    // write enable
  output logic      [ADR_W-1:0] adr_o,   // byte address
  output logic      [3:0]       sel_o,   // byte lanes
  output logic      [31:0]      wdat_o   // write data
);
  int timeouts = 0;  // waits that ran out
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;
  // request held until ack is sampled high, released only after that edge
  // callers load data first, start last, and wait for done
  task xfer(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
            output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    if (ack_i !== 1'b1) begin
      timeouts++;
      $display("CHECK FAILED t=%0t bus answer timed out", $time);
    end
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask : xfer
endmodule : sfe_host_model

/* tb/sfe_top_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// register level tests of the section filter engine
// ****************************************************************
module sfe_top_tb import sfe_pkg::*;;
  logic             clk = 1'b0;  // 200 mhz
  logic             rst = 1'b1;  // sync reset
  logic             cyc, stb, we, ack, irq;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [31:0]      wdat, rdat, q;
  int               errors = 0;
  int               checked = 0;
  localparam logic [31:0] RES = 32'h0010_0088;  // entries 3, 7, 20
  localparam logic [31:0] STS = 32'h0600_0003;  // done, found, index 3
  always #2.5 clk = ~clk;
  sfe_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
  sfe_host_model host_u (.clk_i(clk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [11:0] a);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t at %h got %h exp %h", $time, a, got, exp);
    end
  endtask : chk
  task wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask : wr
  task rc(input logic [ADR_W-1:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, q);
    chk(q, e, a);
  endtask : rc
  // load, start, optionally disturb, then poll done under a bound
  task search(input logic [31:0] res, input logic [31:0] st, input int mode);
    int n;
    wr(OFS_MHI, 32'h1234_5678);
    wr(OFS_MLO, 32'h9abc_def0);
    wr(OFS_MATTR, 32'h0000_4705);
    if (mode == 1) wr(OFS_MHI, 32'hdead_beef);  // goes to the idle buffer
    if (mode == 1) rc(OFS_MHI, 32'hdead_beef);  // reads show the load buffer
    if (mode == 2) repeat (24) @(posedge clk);
    // near cycle 27 the scan is still running: found and index 3 stand, done is low
    if (mode == 2) rc(OFS_STAT, st & 32'hffff_fffe);
    n = 0;
    do begin
      host_u.xfer(1'b0, OFS_STAT, 32'h0, q);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 40);
    chk(q, st, OFS_STAT);
    rc(OFS_RESULT, res);
  endtask : search
  task final_report;
    errors += host_u.timeouts;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rc(OFS_CTRL, 32'h0);
    rc(OFS_RESULT, 32'h0);
    wr(OFS_CTRL, 32'hffff_000f);
    rc(OFS_CTRL, 32'hffff_000a);  // pulse bits read zero
    rc(12'h100, 32'h0);
    wr(OFS_CTRL, 32'h0);
    $display("test registers done");
    // entry 10 wrong pid, 12 wrong fixed byte, 20 differs only under mask
    for (int i = 0; i < 32; i++) begin
      wr(ADR_W'(12'h400 + 16 * i), 32'h1234_5678);
      wr(ADR_W'(12'h404 + 16 * i), (i == 20) ? 32'h9abc_dff0 : 32'h9abc_def0);
      wr(ADR_W'(12'h408 + 16 * i), (i == 10) ? 32'h4746 : (i == 12) ? 32'h4845 :
         (i == 3 || i == 7 || i == 20) ? 32'h4745 : 32'h0745);
      wr(ADR_W'(12'h600 + 8 * i), 32'hffff_ffff);
      wr(ADR_W'(12'h604 + 8 * i), (i == 20) ? 32'hffff_feff : 32'hffff_ffff);
    end
    wr(OFS_IRQ_EN, 32'h3);
    search(RES, STS, 2);  // full scan
    chk({31'h0, irq}, 32'h1, 12'hfff);
    rc(OFS_IRQ_STAT, 32'h3);  // done and found events latched
    wr(OFS_IRQ_CLR, 32'h3);
    rc(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0, 12'hfff);
    $display("test full scan done");
    wr(OFS_CTRL, 32'h2);
    wr(OFS_IRQ_EN, 32'h0);
    search(32'h8, STS, 1);  // stops at entry 3
    chk({31'h0, irq}, 32'h0, 12'hfff);
    wr(OFS_CTRL, 32'h0001_0000);
    search(32'h0, 32'h1, 0);  // equal byte 0 fails
    wr(OFS_CTRL, 32'h0001_0008);
    search(RES, STS, 0);  // entry difference enables are zero
    $display("test difference modes done");
    wr(OFS_CTRL, 32'h0001_0009);  // recovery reset
    rc(OFS_STAT, 32'h0);
    rc(OFS_RESULT, 32'h0);
    rc(OFS_CTRL, 32'h0001_0008);
    search(RES, STS, 0);
    wr(OFS_CTRL, 32'h4);
    rc(OFS_CTRL, 32'h0);
    search(32'h0, 32'h1, 0);  // all entries disabled
    $display("test resets done");
    final_report();
  end
endmodule : sfe_top_tb
